// ---- fsd_sweep_ctrl.sv ----
/*
  Sweep generator control, output divider decode and doubler settings,
  with an APB register slave.
  Assumes the sweep pins and calibration results are synchronous to ref_clk,
  and that the calibration engine pulses done once per request.
*/
module fsd_sweep_ctrl (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire fsd_pkg::fsd_apb_req_t apbReq,
  output fsd_pkg::fsd_apb_rsp_t      apbRsp,
  input  wire logic                  sweepClkPin,
  input  wire logic                  sweepDirPin,
  input  wire fsd_pkg::fsd_cal_res_t calRes,
  output fsd_pkg::fsd_cal_req_t      calReqOut,
  output logic [9:0]                 divideRatio,
  output logic                       dividerBufferOn,
  output logic                       doublerOn,
  output logic [15:0]                doublerBiasWord,
  output logic [32:0]                sweepAccum,
  output logic                       sweepActive
);
  fsd_pkg::fsd_st_t st_q;
  fsd_pkg::fsd_st_t st_d;

  logic [15:0] rg [fsd_pkg::NREG];
  logic        run;
  logic        runRise;
  logic        evA;
  logic        evB;
  logic        curHalf;
  logic        tick;
  logic [15:0] dur;
  logic [1:0]  src;
  logic        succ;
  logic        manual;
  logic [33:0] step34;
  logic [33:0] sum34;
  logic [33:0] ceil34;
  logic [33:0] flr34;
  logic [32:0] clamped;
  logic        segEnd;
  logic        burstStep;
  logic [32:0] diff;
  logic [32:0] mag;
  logic [32:0] limit;
  logic [5:0]  slot;
  logic        access;

  // Maps a register index to its storage slot, bit 5 marks a hit
  function automatic logic [5:0] slotOf(input logic [9:0] idx);
    if (idx == fsd_pkg::IDX_RUN) return {1'b1, 5'(fsd_pkg::S_RUN)};
    else if (idx == fsd_pkg::IDX_BIAS) return {1'b1, 5'(fsd_pkg::S_BIAS)};
    else if (idx == fsd_pkg::IDX_DBL) return {1'b1, 5'(fsd_pkg::S_DBL)};
    else if (idx == fsd_pkg::IDX_DIVBUF) return {1'b1, 5'(fsd_pkg::S_DIVBUF)};
    else if (idx == fsd_pkg::IDX_DIVSEL) return {1'b1, 5'(fsd_pkg::S_DIVSEL)};
    else if (idx == fsd_pkg::IDX_CALSEED) return {1'b1, 5'(fsd_pkg::S_CALSEED)};
    else if (idx == fsd_pkg::IDX_RECAL) return {1'b1, 5'(fsd_pkg::S_RECAL)};
    else if (idx == fsd_pkg::IDX_BURST) return {1'b1, 5'(fsd_pkg::S_BURST)};
    else if (idx == fsd_pkg::IDX_EVT) return {1'b1, 5'(fsd_pkg::S_EVT)};
    else if (idx == fsd_pkg::IDX_S0STEP) return {1'b1, 5'(fsd_pkg::S_S0STEP)};
    else if (idx == fsd_pkg::IDX_S0RATE) return {1'b1, 5'(fsd_pkg::S_S0RATE)};
    else if (idx == fsd_pkg::IDX_S0DUR) return {1'b1, 5'(fsd_pkg::S_S0DUR)};
    else if (idx == fsd_pkg::IDX_SEQ) return {1'b1, 5'(fsd_pkg::S_SEQ)};
    else if (idx == fsd_pkg::IDX_S1H) return {1'b1, 5'(fsd_pkg::S_S1H)};
    else if (idx == fsd_pkg::IDX_S1L) return {1'b1, 5'(fsd_pkg::S_S1L)};
    else if (idx == fsd_pkg::IDX_S1DUR) return {1'b1, 5'(fsd_pkg::S_S1DUR)};
    else if (idx == fsd_pkg::IDX_MODE) return {1'b1, 5'(fsd_pkg::S_MODE)};
    else if (idx == fsd_pkg::IDX_CALW) return {1'b1, 5'(fsd_pkg::S_CALW)};
    else if (idx == fsd_pkg::IDX_CEILH) return {1'b1, 5'(fsd_pkg::S_CEILH)};
    else if (idx == fsd_pkg::IDX_CEILM) return {1'b1, 5'(fsd_pkg::S_CEILM)};
    else if (idx == fsd_pkg::IDX_CEILL) return {1'b1, 5'(fsd_pkg::S_CEILL)};
    else if (idx == fsd_pkg::IDX_FLRH) return {1'b1, 5'(fsd_pkg::S_FLRH)};
    else if (idx == fsd_pkg::IDX_FLRM) return {1'b1, 5'(fsd_pkg::S_FLRM)};
    else if (idx == fsd_pkg::IDX_FLRL) return {1'b1, 5'(fsd_pkg::S_FLRL)};
    else if (idx == fsd_pkg::IDX_BLEN) return {1'b1, 5'(fsd_pkg::S_BLEN)};
    else if (idx == fsd_pkg::IDX_STAT) return {1'b1, 5'(fsd_pkg::S_STAT)};
    else if (idx == fsd_pkg::IDX_ACCH) return {1'b1, 5'(fsd_pkg::S_ACCH)};
    else if (idx == fsd_pkg::IDX_ACCL) return {1'b1, 5'(fsd_pkg::S_ACCL)};
    else return 6'h00;
  endfunction

  function automatic logic evDecode(input logic [3:0] code,
                                    input logic       clkNow,
                                    input logic       clkOld,
                                    input logic       dirNow,
                                    input logic       dirOld);
    case (code)
      fsd_pkg::EV_CLK_RISE: return clkNow & ~clkOld;
      fsd_pkg::EV_DIR_RISE: return dirNow & ~dirOld;
      fsd_pkg::EV_ALWAYS:   return 1'b1;
      fsd_pkg::EV_CLK_FALL: return ~clkNow & clkOld;
      fsd_pkg::EV_DIR_FALL: return ~dirNow & dirOld;
      default:              return 1'b0;
    endcase
  endfunction

  function automatic logic [9:0] ratioOf(input logic [4:0] code);
    case (code)
      5'h00: return 10'h002;
      5'h01: return 10'h004;
      5'h02: return 10'h006;
      5'h03: return 10'h008;
      5'h04: return 10'h00C;
      5'h05: return 10'h010;
      5'h06: return 10'h018;
      5'h07: return 10'h020;
      5'h08: return 10'h030;
      5'h09: return 10'h040;
      5'h0A: return 10'h048;
      5'h0B: return 10'h060;
      5'h0C: return 10'h080;
      5'h0D: return 10'h0C0;
      5'h0E: return 10'h100;
      5'h0F: return 10'h180;
      5'h10: return 10'h200;
      5'h11: return 10'h300;
      default: return 10'h000;
    endcase
  endfunction

  always_comb begin
    for (int i = 0; i < fsd_pkg::NREG; i++) begin
      rg[i] = st_q.regs[i];
    end
  end

  always_comb begin
    st_d      = st_q;
    access    = apbReq.psel & apbReq.penable;
    slot      = slotOf(apbReq.paddr[11:2]);
    run       = rg[fsd_pkg::S_RUN][fsd_pkg::RUN_BIT];
    runRise   = run & ~st_q.runPrev;
    evA = evDecode(rg[fsd_pkg::S_EVT][fsd_pkg::EVA_LSB +: 4], sweepClkPin,
                   st_q.clkPrev, sweepDirPin, st_q.dirPrev);
    evB = evDecode(rg[fsd_pkg::S_EVT][fsd_pkg::EVB_LSB +: 4], sweepClkPin,
                   st_q.clkPrev, sweepDirPin, st_q.dirPrev);
    curHalf = st_q.seg ? rg[fsd_pkg::S_SEQ][fsd_pkg::S1HALF_BIT]
                       : rg[fsd_pkg::S_S0RATE][fsd_pkg::S0HALF_BIT];
    tick    = ~curHalf | st_q.half;
    dur     = st_q.seg ? rg[fsd_pkg::S_S1DUR] : rg[fsd_pkg::S_S0DUR];
    src     = st_q.seg ? rg[fsd_pkg::S_MODE][fsd_pkg::SRC_LSB +: 2]
                       : rg[fsd_pkg::S_SEQ][fsd_pkg::SRC_LSB +: 2];
    succ    = st_q.seg ? rg[fsd_pkg::S_MODE][fsd_pkg::SUCC_BIT]
                       : rg[fsd_pkg::S_SEQ][fsd_pkg::SUCC_BIT];
    manual  = rg[fsd_pkg::S_MODE][fsd_pkg::MANUAL_BIT];
    if (st_q.seg) begin
      step34 = {{4{rg[fsd_pkg::S_S1H][13]}}, rg[fsd_pkg::S_S1H][13:0],
                rg[fsd_pkg::S_S1L]};
    end else begin
      step34 = {{20{rg[fsd_pkg::S_S0STEP][15]}},
                rg[fsd_pkg::S_S0STEP][15:2]};
    end
    sum34  = {st_q.accum[32], st_q.accum} + step34;
    ceil34 = {1'b0, rg[fsd_pkg::S_CEILH][0], rg[fsd_pkg::S_CEILM],
              rg[fsd_pkg::S_CEILL]};
    flr34  = {rg[fsd_pkg::S_FLRH][0], rg[fsd_pkg::S_FLRH][0],
              rg[fsd_pkg::S_FLRM], rg[fsd_pkg::S_FLRL]};
    if ($signed(sum34) > $signed(ceil34)) begin
      clamped = ceil34[32:0];
    end else if ($signed(sum34) < $signed(flr34)) begin
      clamped = flr34[32:0];
    end else begin
      clamped = sum34[32:0];
    end
    case (src)
      fsd_pkg::ADV_SEG: segEnd = tick & ({1'b0, st_q.durCnt} + 17'h00001
                                         >= {1'b0, dur});
      fsd_pkg::ADV_EVA: segEnd = evA;
      fsd_pkg::ADV_EVB: segEnd = evB;
      default:          segEnd = 1'b0;
    endcase
    segEnd = segEnd & (st_q.state == fsd_pkg::ST_RUN);
    case (rg[fsd_pkg::S_EVT][fsd_pkg::BADV_LSB +: 2])
      fsd_pkg::ADV_SEG: burstStep = segEnd;
      fsd_pkg::ADV_EVA: burstStep = evA;
      fsd_pkg::ADV_EVB: burstStep = evB;
      default:          burstStep = 1'b0;
    endcase
    diff  = st_q.accum - st_q.calRef;
    mag   = diff[32] ? 33'(-diff) : diff;
    limit = {16'h0000, rg[fsd_pkg::S_CALSEED][fsd_pkg::RECALHI_BIT],
             rg[fsd_pkg::S_RECAL]};

    st_d.runPrev = run;
    st_d.clkPrev = sweepClkPin;
    st_d.dirPrev = sweepDirPin;
    st_d.calReq  = 1'b0;
    st_d.divRatio = ratioOf(rg[fsd_pkg::S_DIVSEL][fsd_pkg::DIVSEL_LSB +: 5]);
    if (calRes.done) begin
      st_d.foundCore = calRes.core;
      st_d.foundCap  = calRes.cap;
      st_d.foundAmp  = calRes.amp;
    end

    case (st_q.state)
      fsd_pkg::ST_IDLE: begin
        st_d.accum = 33'h000000000;
        if (run && (!rg[fsd_pkg::S_BURST][fsd_pkg::BURSTEN_BIT] || runRise))
        begin
          st_d.state    = fsd_pkg::ST_RUN;
          st_d.seg      = 1'b0;
          st_d.half     = 1'b0;
          st_d.durCnt   = 16'h0000;
          st_d.burstCnt = 16'h0000;
          st_d.calRef   = 33'h000000000;
        end
      end
      fsd_pkg::ST_RUN: begin
        st_d.half = curHalf & ~st_q.half;
        if (tick) begin
          st_d.accum  = clamped;
          st_d.durCnt = st_q.durCnt + 16'h0001;
        end
        if (mag > limit) begin
          st_d.calReq = 1'b1;
          st_d.calRef = st_q.accum;
        end
        if (segEnd) begin
          st_d.seg    = succ;
          st_d.durCnt = 16'h0000;
          st_d.half   = 1'b0;
          if (!manual && (succ ? rg[fsd_pkg::S_SEQ][fsd_pkg::S1CLR_BIT]
                               : rg[fsd_pkg::S_EVT][fsd_pkg::S0CLR_BIT])) begin
            st_d.accum = 33'h000000000;
          end
          if (rg[fsd_pkg::S_CALW][fsd_pkg::CALAFTER_BIT]) begin
            st_d.state   = fsd_pkg::ST_CAL;
            st_d.calReq  = 1'b1;
            st_d.calSeen = 1'b0;
            st_d.calRef  = st_d.accum;
            st_d.waitCnt = 17'({7'h00, rg[fsd_pkg::S_MODE][fsd_pkg::WAIT_LSB
                                      +: 10]}
                              << rg[fsd_pkg::S_CALW][fsd_pkg::SCALE_LSB +: 3]);
          end
        end
        if (rg[fsd_pkg::S_BURST][fsd_pkg::BURSTEN_BIT] && burstStep) begin
          st_d.burstCnt = st_q.burstCnt + 16'h0001;
          if (st_q.burstCnt + 16'h0001 >= rg[fsd_pkg::S_BLEN]) begin
            st_d.state = fsd_pkg::ST_DONE;
          end
        end
      end
      fsd_pkg::ST_CAL: begin
        st_d.calSeen = st_q.calSeen | calRes.done;
        if (st_q.waitCnt != 17'h00000) begin
          st_d.waitCnt = st_q.waitCnt - 17'h00001;
        end
        if ((manual || st_q.waitCnt == 17'h00000)
            && (st_q.calSeen || calRes.done)) begin
          st_d.state = fsd_pkg::ST_RUN;
        end
      end
      default: begin
        if (!run) begin
          st_d.state = fsd_pkg::ST_IDLE;
        end
      end
    endcase
    // sweep off when run bit clear
    if (!run) begin
      st_d.state = fsd_pkg::ST_IDLE;
      st_d.accum = 33'h000000000;
    end

    // Register access: read data prepared in setup, write in access
    if (apbReq.psel && !apbReq.penable) begin
      st_d.pslverr = ~slot[5];
      if (!slot[5]) begin
        st_d.prdata = 32'h00000000;
      end else if (slot[4:0] == 5'(fsd_pkg::S_STAT)) begin
        st_d.prdata = {28'h0000000, st_q.state, st_q.seg,
                       rg[fsd_pkg::S_DIVSEL][10:6] > 5'h11};
      end else if (slot[4:0] == 5'(fsd_pkg::S_ACCH)) begin
        st_d.prdata = {15'h0000, st_q.accum[32:16]};
      end else if (slot[4:0] == 5'(fsd_pkg::S_ACCL)) begin
        st_d.prdata = {16'h0000, st_q.accum[15:0]};
      end else begin
        st_d.prdata = {16'h0000, rg[slot[4:0]]};
      end
    end
    if (access && apbReq.pwrite && slot[5]
        && slot[4:0] < 5'(fsd_pkg::NREG)) begin
      st_d.regs[slot[4:0]] = apbReq.pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.regs[fsd_pkg::S_BIAS] <= fsd_pkg::BIAS_RST;
      st_q.regs[fsd_pkg::S_CALW] <= fsd_pkg::CALW_RST;
      st_q.state <= fsd_pkg::ST_IDLE;
      st_q.divRatio <= 10'h002;
    end else begin
      st_q <= st_d;
    end
  end

  assign apbRsp.pready  = 1'b1;
  assign apbRsp.prdata  = st_q.prdata;
  assign apbRsp.pslverr = st_q.pslverr;
  assign divideRatio    = st_q.divRatio;
  // buffer enable driven from software setting
  assign dividerBufferOn = rg[fsd_pkg::S_DIVBUF][fsd_pkg::DIVBUF_BIT];
  assign doublerOn       = rg[fsd_pkg::S_DBL][fsd_pkg::DBL_BIT];
  assign doublerBiasWord = doublerOn ? rg[fsd_pkg::S_BIAS] : 16'h0000;
  assign sweepAccum      = st_q.accum;
  assign sweepActive     = st_q.state != fsd_pkg::ST_IDLE;
  assign calReqOut.req   = st_q.calReq;
  assign calReqOut.core = rg[fsd_pkg::S_CALSEED][fsd_pkg::REUSE_BIT]
                          ? st_q.foundCore : fsd_pkg::CORE_DFLT;
  assign calReqOut.cap  = rg[fsd_pkg::S_CALSEED][fsd_pkg::REUSE_BIT]
                          ? st_q.foundCap
                          : rg[fsd_pkg::S_CALSEED][fsd_pkg::CAPSEED_LSB +: 8];
  assign calReqOut.amp  = rg[fsd_pkg::S_CALSEED][fsd_pkg::REUSE_BIT]
                          ? st_q.foundAmp : fsd_pkg::AMP_DFLT;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_div_lookup: assert property (
    rg[fsd_pkg::S_DIVSEL][10:6] == 5'h11 ##1
    rg[fsd_pkg::S_DIVSEL][10:6] == 5'h11 |-> divideRatio == 10'h300)
    else $error("divide ratio for code 17 wrong");
  a_bias_gate: assert property (
    !doublerOn |-> doublerBiasWord == 16'h0000)
    else $error("bias word leaks with doubler off");
  a_ceiling_hold: assert property (
    st_q.state == fsd_pkg::ST_RUN && tick && !segEnd
    && $signed(sum34) > $signed(ceil34) && run |=> sweepAccum == $past(ceil34[32:0]))
    else $error("accumulator passed the ceiling");
  a_floor_hold: assert property (
    st_q.state == fsd_pkg::ST_RUN && tick && !segEnd
    && $signed(sum34) < $signed(flr34) && run |=> sweepAccum == $past(flr34[32:0]))
    else $error("accumulator passed the floor");
  a_run_off: assert property (
    !run |=> st_q.state == fsd_pkg::ST_IDLE && sweepAccum == 33'h000000000)
    else $error("sweep active with run bit clear");
  a_half_rate: assert property (
    st_q.state == fsd_pkg::ST_RUN && curHalf && !st_q.half
    && src == fsd_pkg::ADV_SEG && run |=> $stable(st_q.durCnt))
    else $error("half-rate segment advanced on skipped clock");
  a_successor: assert property (
    segEnd && run |=> st_q.seg == $past(succ))
    else $error("wrong successor segment");
  a_cal_after: assert property (
    segEnd && run && rg[fsd_pkg::S_CALW][fsd_pkg::CALAFTER_BIT]
    |=> calReqOut.req ##1 st_q.state == fsd_pkg::ST_CAL || !run)
    else $error("no calibration after segment");
  a_reuse_seed: assert property (
    rg[fsd_pkg::S_CALSEED][fsd_pkg::REUSE_BIT] && calRes.done
    |=> calReqOut.cap == $past(calRes.cap))
    else $error("calibration seed not reused");
  c_burst_done: cover property (st_q.state == fsd_pkg::ST_DONE);
  c_cal_gap: cover property (st_q.state == fsd_pkg::ST_CAL ##1
                             st_q.state == fsd_pkg::ST_RUN);
  c_seg_one: cover property (segEnd && succ);
endmodule

// ---- fsd_pkg.sv ----
/*
  Constants, register map and carrier types of the FMCW sweep and
  output divider control block.
  Assumes a 10 MHz phase-detector clock and an APB master with 32-bit data.
*/
// Function
// - Divide codes 0..17 give ratios 2..768; codes 18..31 reserved.
// - Doubler enable switches doubler path; bias word 0x0624 feeds only it.
// - Request recalibration once sweep frequency change exceeds step limit.
// - Reuse enabled: seed core, band, amplitude from last calibration.
// - Band seed gives starting band code; software keeps it 0..183.
// - Sweep settings act only while run bit is one.
// - Sweep never exceeds ceiling; software sets ceiling at or above start.
// - Sweep never falls below floor; software sets floor at or below start.
// - Burst mode: run bit rising starts burst of programmed length.
// - Burst advance source: segment end, event A, event B, reserved.
// - Event source codes: off, pin edges, always; others reserved.
// - Segment clear bit zeroes accumulator at segment start, automatic only.
// - Signed step added each cycle: 14 bits segment 0, 30 segment 1.
// - Half-rate bit advances segment every second clock.
// - Each segment has 16-bit duration in detector cycles.
// - Segment 0 successor bit: 0 repeats segment 0, 1 goes 1.
// - Segment 1 successor bit: 0 goes to segment 0, 1 repeats.
// - Segment advance source: timeout, event A, event B, reserved.
// - Automatic calibration gap is max of calibration time and wait count.
// - Manual sweep bit: 0 automatic, 1 manual.
// - Calibrate-after-segment bit forces calibration after each segment.
package fsd_pkg;
  localparam int NREG = 25;
  // Storage slots
  localparam int S_RUN = 0, S_BIAS = 1, S_DBL = 2, S_DIVBUF = 3;
  localparam int S_DIVSEL = 4, S_CALSEED = 5, S_RECAL = 6, S_BURST = 7;
  localparam int S_EVT = 8, S_S0STEP = 9, S_S0RATE = 10, S_S0DUR = 11;
  localparam int S_SEQ = 12, S_S1H = 13, S_S1L = 14, S_S1DUR = 15;
  localparam int S_MODE = 16, S_CALW = 17, S_CEILH = 18, S_CEILM = 19;
  localparam int S_CEILL = 20, S_FLRH = 21, S_FLRM = 22, S_FLRL = 23;
  localparam int S_BLEN = 24, S_STAT = 25, S_ACCH = 26, S_ACCL = 27;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_RUN = 10'h000, IDX_BIAS = 10'h019;
  localparam logic [9:0] IDX_DBL = 10'h01B, IDX_DIVBUF = 10'h01F;
  localparam logic [9:0] IDX_DIVSEL = 10'h04B, IDX_CALSEED = 10'h04E;
  localparam logic [9:0] IDX_RECAL = 10'h04F, IDX_BURST = 10'h060;
  localparam logic [9:0] IDX_EVT = 10'h061, IDX_S0STEP = 10'h062;
  localparam logic [9:0] IDX_S0RATE = 10'h063, IDX_S0DUR = 10'h064;
  localparam logic [9:0] IDX_SEQ = 10'h065, IDX_S1H = 10'h066;
  localparam logic [9:0] IDX_S1L = 10'h067, IDX_S1DUR = 10'h068;
  localparam logic [9:0] IDX_MODE = 10'h069, IDX_CALW = 10'h06A;
  localparam logic [9:0] IDX_CEILH = 10'h070, IDX_CEILM = 10'h071;
  localparam logic [9:0] IDX_CEILL = 10'h072, IDX_FLRH = 10'h073;
  localparam logic [9:0] IDX_FLRM = 10'h074, IDX_FLRL = 10'h075;
  localparam logic [9:0] IDX_STAT = 10'h076, IDX_ACCH = 10'h077;
  localparam logic [9:0] IDX_ACCL = 10'h078, IDX_BLEN = 10'h079;
  // Field positions
  localparam int RUN_BIT = 15, DBL_BIT = 0, DIVBUF_BIT = 14, DIVSEL_LSB = 6;
  localparam int RECALHI_BIT = 11, REUSE_BIT = 9, CAPSEED_LSB = 1;
  localparam int BURSTEN_BIT = 15, BADV_LSB = 0, EVA_LSB = 3, EVB_LSB = 7;
  localparam int S0CLR_BIT = 15, S0HALF_BIT = 0, S1HALF_BIT = 6;
  localparam int S1CLR_BIT = 5, SUCC_BIT = 4, SRC_LSB = 0, MANUAL_BIT = 5;
  localparam int WAIT_LSB = 6, CALAFTER_BIT = 4, SCALE_LSB = 0;
  // Values after reset
  localparam logic [15:0] BIAS_RST = 16'h0624;
  localparam logic [15:0] CALW_RST = 16'h0007;
  localparam logic [2:0] CORE_DFLT = 3'h1;
  localparam logic [8:0] AMP_DFLT = 9'h0AA;
  // Event source and advance source codes
  localparam logic [3:0] EV_CLK_RISE = 4'h1, EV_DIR_RISE = 4'h2;
  localparam logic [3:0] EV_ALWAYS = 4'h4, EV_CLK_FALL = 4'h9;
  localparam logic [3:0] EV_DIR_FALL = 4'hA;
  localparam logic [1:0] ADV_SEG = 2'h0, ADV_EVA = 2'h1, ADV_EVB = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CAL, ST_DONE} fsd_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fsd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } fsd_apb_rsp_t;

  typedef struct packed {
    logic       done;
    logic [2:0] core;
    logic [7:0] cap;
    logic [8:0] amp;
  } fsd_cal_res_t;

  typedef struct packed {
    logic       req;
    logic [2:0] core;
    logic [7:0] cap;
    logic [8:0] amp;
  } fsd_cal_req_t;

  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    fsd_state_t            state;
    logic                  seg;
    logic                  half;
    logic [15:0]           durCnt;
    logic [32:0]           accum;
    logic [32:0]           calRef;
    logic [15:0]           burstCnt;
    logic [16:0]           waitCnt;
    logic                  calSeen;
    logic                  runPrev;
    logic                  clkPrev;
    logic                  dirPrev;
    logic                  calReq;
    logic [2:0]            foundCore;
    logic [7:0]            foundCap;
    logic [8:0]            foundAmp;
    logic [9:0]            divRatio;
    logic [31:0]           prdata;
    logic                  pslverr;
  } fsd_st_t;
endpackage

// ---- fsd_trig_model.sv ----
/* Model of the external controller that drives the two sweep trigger pins.
   Assumes trigger requests are one-cycle pulses synchronous to ref_clk. */
module fsd_trig_model (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic pulseReq,
  output logic      sweepClkPin,
  output logic      sweepDirPin
);
  // clock pin pulse, direction pin toggle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sweepClkPin <= 1'b0;
      sweepDirPin <= 1'b0;
    end else begin
      sweepClkPin <= pulseReq;
      sweepDirPin <= sweepDirPin ^ pulseReq;
    end
  end
endmodule

// ---- fsd_sweep_ctrl_tb_top.sv ----
/* Self-checking bench for the sweep and divider control block.
   Assumes the trigger model is compiled before it. */
module fsd_sweep_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [4:0] code; logic [9:0] ratio;} fsd_row_t;
  fsd_row_t              rows [20] = '{'{0, 2}, '{1, 4}, '{2, 6}, '{3, 8},
    '{4, 12}, '{5, 16}, '{6, 24}, '{7, 32}, '{8, 48}, '{9, 64}, '{10, 72},
    '{11, 96}, '{12, 128}, '{13, 192}, '{14, 256}, '{15, 384}, '{16, 512},
    '{17, 768}, '{18, 0}, '{31, 0}};
  logic                  ref_clk, reset, pulseReq, err;
  logic                  sweepClkPin, sweepDirPin, sweepActive;
  logic                  dividerBufferOn, doublerOn;
  fsd_pkg::fsd_apb_req_t apbReq;
  fsd_pkg::fsd_apb_rsp_t apbRsp;
  fsd_pkg::fsd_cal_res_t calRes;
  fsd_pkg::fsd_cal_req_t calReqOut;
  logic [9:0]            divideRatio;
  logic [15:0]           doublerBiasWord;
  logic [32:0]           sweepAccum;
  logic [31:0]           rdat;
  int                    fails, cmp_count, cyc, calCnt, c0;

  fsd_sweep_ctrl fsd_sweep_ctrl_i (.ref_clk, .reset, .apbReq, .apbRsp,
    .sweepClkPin, .sweepDirPin, .calRes, .calReqOut, .divideRatio,
    .dividerBufferOn, .doublerOn, .doublerBiasWord, .sweepAccum,
    .sweepActive);
  fsd_trig_model fsd_trig_model_i (.ref_clk, .reset, .pulseReq,
    .sweepClkPin, .sweepDirPin);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Calibration engine stand-in and run limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    calRes.done <= calReqOut.req;
    if (calReqOut.req === 1'b1)
      calCnt <= calCnt + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [15:0] d);
    @(posedge ref_clk);
    apbReq <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {16'h0000, d}};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    @(posedge ref_clk);
    while (apbRsp.pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdat = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run(input logic [15:0] v, input int n);
    apb(1, fsd_pkg::IDX_RUN, v);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    pulseReq = 1'b0;
    apbReq = '0;
    calRes = '{1'b0, 3'h2, 8'h22, 9'h055};
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    apb(0, fsd_pkg::IDX_BIAS, 0);
    chk("bias", 16'h0624, rdat);
    apb(0, fsd_pkg::IDX_CALW, 0);
    chk("scale", 7, rdat);
    apb(0, 10'h3FF, 0);
    chk("unmapped", 1, err);
    chk("active", 0, sweepActive);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, fsd_pkg::IDX_DIVBUF, {1'b0, rows[i].code != 0, 14'h0});
      apb(1, fsd_pkg::IDX_DIVSEL, {5'h0, rows[i].code, 6'h0});
      repeat (2) @(posedge ref_clk);
      chk("ratio", rows[i].ratio, divideRatio);
      chk("bufOn", rows[i].code != 0, dividerBufferOn);
    end
    $display("divider test done");
    apb(1, fsd_pkg::IDX_DBL, 16'h0001);
    repeat (2) @(posedge ref_clk);
    chk("dblOn", 1, doublerOn);
    chk("biasOut", 16'h0624, doublerBiasWord);
    apb(1, fsd_pkg::IDX_DBL, 16'h0000);
    repeat (2) @(posedge ref_clk);
    chk("biasOut", 0, doublerBiasWord);
    $display("doubler test done");
    apb(1, fsd_pkg::IDX_CEILL, 16'h000A);
    apb(1, fsd_pkg::IDX_S0STEP, 16'h000C);
    apb(1, fsd_pkg::IDX_S0DUR, 16'h0003);
    c0 = calCnt;
    run(16'h8000, 20);
    chk("ceiling", 10, sweepAccum);
    chk("recal", 1, calCnt > c0);
    run(16'h0000, 2);
    chk("stopped", 0, sweepAccum);
    chk("idle", 0, sweepActive);
    apb(1, fsd_pkg::IDX_FLRH, 16'h0001);
    apb(1, fsd_pkg::IDX_FLRM, 16'hFFFF);
    apb(1, fsd_pkg::IDX_FLRL, 16'hFFF9);
    apb(1, fsd_pkg::IDX_S0STEP, 16'hFFF4);
    run(16'h8000, 20);
    chk("floor", 33'h1FFFFFFF9, sweepAccum);
    run(16'h0000, 2);
    $display("limit test done");
    apb(1, fsd_pkg::IDX_CALSEED, 16'h016E);
    @(posedge ref_clk);
    chk("seedCap", 8'hB7, calReqOut.cap);
    apb(1, fsd_pkg::IDX_RECAL, 16'hFFFF);
    apb(1, fsd_pkg::IDX_CALW, 16'h0017);
    c0 = calCnt;
    run(16'h8000, 40);
    chk("calAfter", 1, calCnt > c0 + 1);
    apb(1, fsd_pkg::IDX_CALSEED, 16'h036E);
    @(posedge ref_clk);
    chk("reuseCap", 8'h22, calReqOut.cap);
    chk("reuseCore", 3'h2, calReqOut.core);
    chk("reuseAmp", 9'h055, calReqOut.amp);
    run(16'h0000, 2);
    $display("calibration test done");
    apb(1, fsd_pkg::IDX_CALW, 16'h0007);
    apb(1, fsd_pkg::IDX_EVT, 16'h0008);
    apb(1, fsd_pkg::IDX_SEQ, 16'h0011);
    apb(1, fsd_pkg::IDX_MODE, 16'h0010);
    run(16'h8000, 10);
    apb(0, fsd_pkg::IDX_STAT, 0);
    chk("segWait", 0, rdat[1]);
    pulseReq <= 1'b1;
    @(posedge ref_clk);
    pulseReq <= 1'b0;
    repeat (10) @(posedge ref_clk);
    apb(0, fsd_pkg::IDX_STAT, 0);
    chk("segNext", 1, rdat[1]);
    $display("event test done");
    run(16'h0000, 2);
    apb(1, fsd_pkg::IDX_SEQ, 16'h0000);
    apb(1, fsd_pkg::IDX_EVT, 16'h0000);
    apb(1, fsd_pkg::IDX_S0RATE, 16'h0001);
    apb(1, fsd_pkg::IDX_S0STEP, 16'h0004);
    apb(1, fsd_pkg::IDX_BLEN, 16'h0003);
    apb(1, fsd_pkg::IDX_BURST, 16'h8000);
    run(16'h8000, 8);
    chk("halfRate", 3, sweepAccum);
    repeat (20) @(posedge ref_clk);
    chk("burstEnd", 9, sweepAccum);
    chk("burstHold", 1, sweepActive);
    $display("burst test done");
    conclude();
  end
endmodule
